// ===== design/lbh_pkg.sv
// Package: constants and state type for local bus hold arbitration
`default_nettype none
package lbh_pkg;
   // Role encoding of the role select bit
   localparam logic LBH_ROLE_MASTER = 1'b1;
   localparam logic LBH_ROLE_SLAVE  = 1'b0;
   // Reset value of the role bit: slave
   localparam logic LBH_ROLE_RESET  = 1'b0;
   // Bus clock period in ns and in sys_clk cycles (one bus clock per sys_clk)
   localparam int   LBH_BUSCLK_NS   = 8;
   localparam int   LBH_CLK_NS      = 8;
   localparam int   LBH_BUSCLK_CYC  = (LBH_BUSCLK_NS + LBH_CLK_NS - 1) / LBH_CLK_NS;
   localparam logic [3:0] LBH_BUSCLK_CNT = 4'(LBH_BUSCLK_CYC);
   localparam logic [3:0] LBH_CNT_ZERO = 4'h0;
   localparam logic [3:0] LBH_CNT_ONE  = 4'h1;
   // Synchroniser depth
   localparam int   LBH_SYNC_STAGES = 2;

   // Arbitration states, Gray coded from OWN through DRAIN, RELEASE and HOLD to REGAIN
   typedef enum logic [2:0] {
      LBH_ST_OWN      = 3'b000,  // driving the bus
      LBH_ST_DRAIN    = 3'b001,  // finishing cycle before release
      LBH_ST_RELEASE  = 3'b011,  // bus released, ack not yet shown
      LBH_ST_HOLD     = 3'b010,  // in hold
      LBH_ST_REGAIN   = 3'b110   // ack raised, bus not yet driven
   } lbh_state_t;
endpackage : lbh_pkg
`default_nettype wire

// ===== design/lbh_sync.sv
// Two-stage synchroniser with edge detection on the synchronised level
`default_nettype none
module lbh_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic sys_clk,
   input  wire logic srst,
   input  wire logic din,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta_r;
   logic meta_nxt;
   logic sync_r;
   logic sync_nxt;
   logic prev_r;
   logic prev_nxt;

   always_comb begin
      meta_nxt = din;
      sync_nxt = meta_r;
      prev_nxt = sync_r;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         meta_r <= RESET_VAL;
         sync_r <= RESET_VAL;
         prev_r <= RESET_VAL;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         prev_r <= prev_nxt;
      end
   end

   assign level = sync_r;
   assign rise  = sync_r & ~prev_r;
   assign fall  = ~sync_r & prev_r;
endmodule : lbh_sync
`default_nettype wire

// ===== design/lbh_arbiter.sv
// Local bus hold arbitration: master and slave roles on one shared bus
// Contract
// R1: Rising hold request, synchronised, raises acknowledge then drives bus again.
// R2: In hold, needing the bus, assert bus request low.
// R3: Bus regain starts only on hold request going high.
// R4: Other party may release hold request anytime; device then regains bus.
// R5: Role bit 1 selects arbitration master, 0 selects slave.
// R6: Hold enable 1 responds to arbitration; 0 keeps bus, no hold.
// R7: Master drives latch enable, write and read strobes; slave inputs them. The code drives them in either role only while it owns the bus.
// R8: Only one controller drives shared bus; the other tristates.
// R9: Master: falling hold request releases bus, then acknowledge low, hold.
// R10: Master leaving hold raises acknowledge before driving bus.
// R11: Master bus request high normally; low earliest one bus clock after acknowledge.
// R12: Master returns bus request high one bus clock after acknowledge rises.
// R13: Slave with hold request and acknowledge high is held, tristated.
// R14: Slave returns to hold on low request after one full cycle.
// R15: Slave: falling acknowledge input releases it from hold.
// R16: Slave requests bus low when access needed, waits for acknowledge.
// R17: Slave raises bus request only after fully backing off bus.
// R18: Reset leaves the device in slave role.
// R19: Software sets role bit to master before setting hold enable.
// R20: Master with hold enable cleared ignores hold requests; pins stay arbitration.
// R21: Before granting hold, synchronise request and finish current cycle.
// R22: In hold, address, data and command lines are tristated inputs.
// R23: Hold request and acknowledge pass two flip-flops; edges on synced values.
`default_nettype none
module lbh_arbiter (
   input  wire logic sys_clk,
   input  wire logic srst,
   // Configuration
   input  wire logic arb_role_sel,
   input  wire logic hold_response_en,
   // Bus engine side
   input  wire logic ext_access_req,
   input  wire logic bus_cycle_active,
   output logic      bus_granted,
   output logic      bus_drive_en,
   output logic      cmd_drive_en,
   output logic      ale_drive_en,
   output logic      hold_status,
   // Arbitration pins
   input  wire logic hold_request_n,
   input  wire logic hold_ack_n_in,
   output logic      hold_ack_n_out,
   output logic      hold_ack_n_oe,
   output logic      bus_request_n
);
   lbh_pkg::lbh_state_t state_r;
   lbh_pkg::lbh_state_t state_nxt;
   logic                role_r;
   logic                role_nxt;
   logic                ack_n_r;
   logic                ack_n_nxt;
   logic                breq_n_r;
   logic                breq_n_nxt;
   logic [3:0]          tcl_cnt_r;
   logic [3:0]          tcl_cnt_nxt;
   logic                tcl_load;
   logic                cycle_done_r;
   logic                cycle_done_nxt;
   logic                hreq_lvl;
   logic                hack_lvl;
   logic                hack_fall;
   logic                is_master;

   // Spacing reload: the count left after the loading edge
   localparam logic [3:0] SPACING_RELOAD = lbh_pkg::LBH_BUSCLK_CNT - lbh_pkg::LBH_CNT_ONE;

   // -------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------
   // R23 two-stage synchronisers
   lbh_sync #(.RESET_VAL(1'b1)) u_sync_hreq (
      .sys_clk (sys_clk),
      .srst    (srst),
      .din     (hold_request_n),
      .level   (hreq_lvl),
      .rise    (),
      .fall    ()
   );

   lbh_sync #(.RESET_VAL(1'b1)) u_sync_hack (
      .sys_clk (sys_clk),
      .srst    (srst),
      .din     (hold_ack_n_in),
      .level   (hack_lvl),
      .rise    (),
      .fall    (hack_fall)
   );

   // -------------------------------------------------------------
   // Decode helpers
   // -------------------------------------------------------------
   // Role bit decode
   function automatic logic role_is_master(input logic role);
      return role == lbh_pkg::LBH_ROLE_MASTER;
   endfunction : role_is_master

   // States that still drive the shared bus
   function automatic logic state_drives(input lbh_pkg::lbh_state_t st);
      return (st == lbh_pkg::LBH_ST_OWN) || (st == lbh_pkg::LBH_ST_DRAIN);
   endfunction : state_drives

   // Spacing count run out
   function automatic logic cnt_expired(input logic [3:0] cnt);
      return cnt == lbh_pkg::LBH_CNT_ZERO;
   endfunction : cnt_expired

   assign is_master = role_is_master(role_r);

   // -------------------------------------------------------------
   // Role register
   // -------------------------------------------------------------
   always_comb begin
      // R5 role select
      role_nxt = arb_role_sel;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         // R18 reset into slave role
         role_r <= lbh_pkg::LBH_ROLE_RESET;
      end else begin
         role_r <= role_nxt;
      end
   end

   // -------------------------------------------------------------
   // Spacing counter
   // -------------------------------------------------------------
   always_comb begin
      tcl_cnt_nxt = tcl_cnt_r;
      if (tcl_load) begin
         tcl_cnt_nxt = SPACING_RELOAD;
      end else if (!cnt_expired(tcl_cnt_r)) begin
         tcl_cnt_nxt = tcl_cnt_r - lbh_pkg::LBH_CNT_ONE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tcl_cnt_r <= lbh_pkg::LBH_CNT_ZERO;
      end else begin
         tcl_cnt_r <= tcl_cnt_nxt;
      end
   end

   // -------------------------------------------------------------
   // Completed cycle tracker
   // -------------------------------------------------------------
   // R14 one full external cycle since taking the bus
   always_comb begin
      cycle_done_nxt = cycle_done_r;
      if (state_r == lbh_pkg::LBH_ST_REGAIN) begin
         cycle_done_nxt = 1'b0;
      end else if ((state_r == lbh_pkg::LBH_ST_OWN) && bus_cycle_active) begin
         cycle_done_nxt = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cycle_done_r <= 1'b0;
      end else begin
         cycle_done_r <= cycle_done_nxt;
      end
   end

   // -------------------------------------------------------------
   // Arbitration state machine
   // -------------------------------------------------------------
   always_comb begin
      state_nxt  = state_r;
      ack_n_nxt  = ack_n_r;
      breq_n_nxt = breq_n_r;
      tcl_load   = 1'b0;
      if (is_master) begin
         unique case (state_r)
            lbh_pkg::LBH_ST_OWN: begin
               ack_n_nxt = 1'b1;
               // R12 request returns high one bus clock after ack rise
               if (cnt_expired(tcl_cnt_r)) begin
                  breq_n_nxt = 1'b1;
               end
               // R6 R9 R20 falling request starts release, gated by enable
               if (hold_response_en && !hreq_lvl && breq_n_r) begin
                  state_nxt = lbh_pkg::LBH_ST_DRAIN;
               end
            end
            lbh_pkg::LBH_ST_DRAIN: begin
               // R21 finish the running cycle first
               if (!hreq_lvl && !bus_cycle_active) begin
                  state_nxt = lbh_pkg::LBH_ST_RELEASE;
               end else if (hreq_lvl) begin
                  state_nxt = lbh_pkg::LBH_ST_OWN;
               end
            end
            lbh_pkg::LBH_ST_RELEASE: begin
               // R9 ack low only after bus released
               ack_n_nxt = 1'b0;
               tcl_load  = 1'b1;
               state_nxt = lbh_pkg::LBH_ST_HOLD;
            end
            lbh_pkg::LBH_ST_HOLD: begin
               // R11 R2 request no earlier than one bus clock after ack
               if (ext_access_req && cnt_expired(tcl_cnt_r)) begin
                  breq_n_nxt = 1'b0;
               end
               // R3 R4 R1 regain only on rising request
               if (hreq_lvl) begin
                  ack_n_nxt = 1'b1;
                  tcl_load  = 1'b1;
                  state_nxt = lbh_pkg::LBH_ST_REGAIN;
               end
            end
            lbh_pkg::LBH_ST_REGAIN: begin
               // R10 ack already high, now drive the bus
               state_nxt = lbh_pkg::LBH_ST_OWN;
               // R12 request back high one bus clock after ack
               if (cnt_expired(tcl_cnt_r)) begin
                  breq_n_nxt = 1'b1;
               end
            end
            default: begin
               state_nxt = lbh_pkg::LBH_ST_HOLD;
            end
         endcase
      end else begin
         ack_n_nxt = 1'b1;
         unique case (state_r)
            lbh_pkg::LBH_ST_HOLD: begin
               // R16 request low on access need
               if (hold_response_en && ext_access_req) begin
                  breq_n_nxt = 1'b0;
               end else if (breq_n_r) begin
                  breq_n_nxt = 1'b1;
               end
               // R15 falling ack input releases slave
               if (hack_fall && !breq_n_r) begin
                  state_nxt = lbh_pkg::LBH_ST_REGAIN;
               end
            end
            lbh_pkg::LBH_ST_REGAIN: begin
               state_nxt = lbh_pkg::LBH_ST_OWN;
            end
            lbh_pkg::LBH_ST_OWN: begin
               // R14 back to hold after one complete cycle
               if (!hreq_lvl && cycle_done_r && !bus_cycle_active) begin
                  state_nxt = lbh_pkg::LBH_ST_RELEASE;
               end
               // R13 both high returns to hold
               if (hreq_lvl && hack_lvl && breq_n_r) begin
                  state_nxt = lbh_pkg::LBH_ST_HOLD;
               end
            end
            lbh_pkg::LBH_ST_RELEASE: begin
               // R17 raise request once off the bus
               breq_n_nxt = 1'b1;
               state_nxt  = lbh_pkg::LBH_ST_HOLD;
            end
            default: begin
               state_nxt = lbh_pkg::LBH_ST_HOLD;
            end
         endcase
      end
      // Role change restarts the arbitration
      if (is_master != role_is_master(role_nxt)) begin
         state_nxt  = lbh_pkg::LBH_ST_HOLD;
         ack_n_nxt  = 1'b1;
         breq_n_nxt = 1'b1;
         if (role_is_master(role_nxt)) begin
            state_nxt = lbh_pkg::LBH_ST_OWN;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         // R18 reset held, arbitration pins idle
         state_r  <= lbh_pkg::LBH_ST_HOLD;
         ack_n_r  <= 1'b1;
         breq_n_r <= 1'b1;
      end else begin
         state_r  <= state_nxt;
         ack_n_r  <= ack_n_nxt;
         breq_n_r <= breq_n_nxt;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   // R8 R22 drive only while owning the bus
   assign bus_drive_en   = state_drives(state_r);
   // R7 strobes driven only when owning the bus
   assign cmd_drive_en   = bus_drive_en;
   assign ale_drive_en   = bus_drive_en;
   assign bus_granted    = bus_drive_en && !(state_r == lbh_pkg::LBH_ST_DRAIN);
   assign hold_status    = (state_r == lbh_pkg::LBH_ST_HOLD);
   // R5 ack is an output only in master role
   assign hold_ack_n_out = ack_n_r;
   assign hold_ack_n_oe  = is_master;
   assign bus_request_n  = breq_n_r;
endmodule : lbh_arbiter
`default_nettype wire

// ===== tb/lbh_arbiter_chk.sv
// Checker: arbitration pin timing of lbh_arbiter
`default_nettype none
module lbh_arbiter_chk (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic arb_role_sel,
   input wire logic hold_response_en,
   input wire logic ext_access_req,
   input wire logic bus_cycle_active,
   input wire logic bus_granted,
   input wire logic bus_drive_en,
   input wire logic cmd_drive_en,
   input wire logic ale_drive_en,
   input wire logic hold_status,
   input wire logic hold_request_n,
   input wire logic hold_ack_n_in,
   input wire logic hold_ack_n_out,
   input wire logic hold_ack_n_oe,
   input wire logic bus_request_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic mst;
   assign mst = arb_role_sel & hold_ack_n_oe;
   rel_first_a: assert property (mst && $fell(hold_ack_n_out) |-> !bus_drive_en && !$past(bus_drive_en))
      else $error("ack fell while driving");
   ack_first_a: assert property (mst && $rose(bus_drive_en) |-> hold_ack_n_out && $past(hold_ack_n_out))
      else $error("drive before ack high");
   breq_late_a: assert property (mst && $fell(bus_request_n) |-> !$past(hold_ack_n_out))
      else $error("request too early");
   breq_back_a: assert property (mst && $rose(hold_ack_n_out) && !bus_request_n |=> bus_request_n)
      else $error("request not returned");
   hold_float_a: assert property (hold_status |-> !bus_drive_en && !cmd_drive_en && !ale_drive_en)
      else $error("driving in hold");
   oe_role_a: assert property (!$past(srst) && $stable(arb_role_sel) |-> hold_ack_n_oe == arb_role_sel)
      else $error("ack enable wrong");
   hold_off_a: assert property (mst && !hold_response_en && bus_granted |=> bus_granted)
      else $error("hold taken while off");
   sync_lag_a: assert property (mst && $fell(hold_request_n) && bus_drive_en |=> bus_drive_en [*2])
      else $error("release before sync");
   slv_back_a: assert property (!arb_role_sel && $rose(bus_request_n) |-> !bus_drive_en && !$past(bus_drive_en))
      else $error("request up while driving");
   cover property (hold_status && !bus_request_n);
   cover property ($rose(bus_drive_en) && hold_ack_n_oe);
   cover property ($fell(hold_ack_n_in) && !arb_role_sel);
endmodule : lbh_arbiter_chk
bind lbh_arbiter lbh_arbiter_chk chk (.*);
`default_nettype wire

// ===== tb/lbh_partner.sv
// Partner: far-side arbiter driving hold request and acknowledge
`default_nettype none
module lbh_partner (
   input wire logic  sys_clk,
   input wire logic  take_bus,
   input wire logic  slow,
   input wire logic  bus_request_n,
   output var logic  hold_request_n,
   output var logic  hold_ack_n_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] req_r = 4'hf;
   logic [3:0] ack_r = 4'hf;
   always @(posedge sys_clk) begin
      req_r <= {req_r[2:0], ~take_bus};
      ack_r <= {ack_r[2:0], bus_request_n};
   end
   assign hold_request_n = slow ? req_r[3] : req_r[0];
   assign hold_ack_n_in  = slow ? ack_r[3] : ack_r[0];
endmodule : lbh_partner
`default_nettype wire

// ===== tb/test_local_bus_hold_arbitration.sv
// Testbench: master and slave arbitration scenarios
`default_nettype none
module test_local_bus_hold_arbitration;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, srst = 1'b1, arb_role_sel = 1'b0, hold_response_en = 1'b0;
   logic ext_access_req = 1'b0, bus_cycle_active = 1'b0, take_bus = 1'b0, slow = 1'b0;
   logic bus_granted, bus_drive_en, cmd_drive_en, ale_drive_en, hold_status;
   logic hold_request_n, hold_ack_n_in, hold_ack_n_out, hold_ack_n_oe, bus_request_n;
   int   miscompares = 0;
   int   check_count = 0;
   lbh_arbiter uut (.*);
   lbh_partner far (.*);
   always #4 sys_clk = ~sys_clk;
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic chk(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   task automatic t_master;
      @(posedge sys_clk) arb_role_sel <= 1'b1;
      @(posedge sys_clk) hold_response_en <= 1'b1;
      tick(4);
      chk("own", 1'b1, bus_drive_en & ale_drive_en);
      @(posedge sys_clk) {take_bus, bus_cycle_active} <= 2'h3;
      tick(8);
      chk("in cycle", 1'b1, bus_drive_en);
      @(posedge sys_clk) bus_cycle_active <= 1'b0;
      repeat (20) if (hold_ack_n_out !== 1'b0) tick(1);
      chk("ack", 1'b0, hold_ack_n_out | cmd_drive_en);
      @(posedge sys_clk) ext_access_req <= 1'b1;
      tick(6);
      chk("breq", 1'b0, bus_request_n);
      chk("held", 1'b1, hold_status);
      @(posedge sys_clk) take_bus <= 1'b0;
      repeat (20) if (bus_drive_en !== 1'b1) tick(1);
      chk("regain", 1'b1, bus_drive_en & hold_ack_n_out);
      tick(2);
      chk("breq up", 1'b1, bus_request_n);
      @(posedge sys_clk) {ext_access_req, hold_response_en, take_bus} <= 3'h1;
      tick(10);
      chk("no hold", 1'b1, hold_ack_n_out & bus_drive_en);
      @(posedge sys_clk) take_bus <= 1'b0;
      tick(4);
      @(posedge sys_clk) hold_response_en <= 1'b1;
      tick(2);
      chk("still own", 1'b1, bus_granted);
      $display("master test done");
   endtask : t_master
   task automatic t_slave;
      @(posedge sys_clk) {arb_role_sel, slow} <= 2'h1;
      tick(6);
      chk("slave held", 1'b1, hold_status);
      @(posedge sys_clk) ext_access_req <= 1'b1;
      repeat (30) if (bus_drive_en !== 1'b1) tick(1);
      chk("slave on", 1'b1, bus_drive_en);
      @(posedge sys_clk) {take_bus, ext_access_req} <= 2'h2;
      tick(12);
      chk("one cycle", 1'b1, bus_drive_en);
      @(posedge sys_clk) bus_cycle_active <= 1'b1;
      tick(2);
      @(posedge sys_clk) bus_cycle_active <= 1'b0;
      repeat (30) if (bus_request_n !== 1'b1) tick(1);
      chk("slave off", 1'b0, bus_drive_en);
      @(posedge sys_clk) take_bus <= 1'b0;
      tick(12);
      chk("rehold", 1'b1, hold_status);
      $display("slave test done");
   endtask : t_slave
   initial begin
      tick(4);
      @(posedge sys_clk) srst <= 1'b0;
      tick(2);
      chk("reset", 1'b1, hold_status & bus_request_n & ~hold_ack_n_oe);
      $display("reset test done");
      t_master;
      t_slave;
      report_and_stop;
   end
   initial begin
      tick(3000);
      miscompares++;
      report_and_stop;
   end
endmodule : test_local_bus_hold_arbitration
`default_nettype wire
